// ### hw/mih_core.sv
// Purpose: Management interrupt generation with end-of-handler handshake
// Assumes: Event pulses come from logic on mclk; AXI4-Lite master on mclk
// Notes: One write and one read handled at a time; no interrupt logic beyond outputs
//
// How it works
// - Management interrupts only arise while the global enable bit is set.
// - An enabled event while the flag is set clears the flag.
// - Interrupt output stays asserted while the flag stays cleared.
// - Events during a cleared flag set status but cause no new assertion.
// - Setting the flag drives the output inactive at least one clock.
// - Flag set with status pending clears it again and re-asserts.
// - Writing the flag takes effect only when all status bits are clear.
// - Summary status bits are group ORs, not writable by software.
// - Route bit sends events to config-power interrupt instead of management.
//
// Our own choices: register access over AXI4-Lite and the register addresses.
module mih_core
  import mih_pkg::*;
#(
  parameter int NUM_EVENTS = 8,
  parameter int GROUP_SIZE = 4,
  parameter int ADDR_W = 8
)
(
  input wire logic mclk, // 125 MHz clock
  input wire logic nrst, // Async reset, active low
  input wire logic [NUM_EVENTS-1:0] event_pulse, // Event sources, one-cycle pulses
  output logic mgmt_interrupt_n, // Management interrupt, active low
  output logic config_power_interrupt, // Config-power interrupt, active high
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);

  localparam int NUM_GROUPS = NUM_EVENTS / GROUP_SIZE;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val, input logic [31:0] new_val,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        res[8*b +: 8] = new_val[8*b +: 8];
    end
    return res;
  endfunction : merge_bytes

  function automatic logic [7:0] word_addr(input logic [ADDR_W-1:0] addr);
    return {addr[7:2], 2'b00};
  endfunction : word_addr

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= MIH_RST_ZERO;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= MIH_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= word_addr(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == MIH_OFF_CTRL || aw_addr == MIH_OFF_STAT || aw_addr == MIH_OFF_ENAB)
                       ? MIH_RESP_OKAY : MIH_RESP_DECERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, enable and status registers
  logic mgmt_int_global_enable;
  logic acpi_route_select;
  logic end_of_handler_flag;
  logic armed;
  logic [NUM_EVENTS-1:0] event_enable;
  logic [NUM_EVENTS-1:0] status;
  logic [NUM_GROUPS-1:0] summary;
  logic [31:0] ctrl_new;
  logic [31:0] stat_bytes;
  logic [31:0] enab_new;
  logic [NUM_EVENTS-1:0] clear_mask;
  logic eoh_write;
  logic pending;
  logic mgmt_req;

  assign ctrl_new = merge_bytes(MIH_RST_ZERO, w_data, w_strb);
  assign stat_bytes = merge_bytes(MIH_RST_ZERO, w_data, w_strb);
  assign enab_new = merge_bytes({{(32-NUM_EVENTS){1'b0}}, event_enable}, w_data, w_strb);
  assign clear_mask = (do_write && aw_addr == MIH_OFF_STAT) ? stat_bytes[NUM_EVENTS-1:0] : '0;
  assign eoh_write = do_write && aw_addr == MIH_OFF_CTRL && w_strb[0] && ctrl_new[MIH_CTRL_EOH];

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      mgmt_int_global_enable <= 1'b0;
      acpi_route_select <= 1'b0;
      event_enable <= '0;
    end
    else if (do_write && aw_addr == MIH_OFF_CTRL && w_strb[0])
    begin
      mgmt_int_global_enable <= ctrl_new[MIH_CTRL_GLOBAL_EN];
      acpi_route_select <= ctrl_new[MIH_CTRL_ROUTE];
    end
    else if (do_write && aw_addr == MIH_OFF_ENAB)
      event_enable <= enab_new[NUM_EVENTS-1:0];
  end

  // Set beats clear so an event in the clearing cycle is kept
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      status <= '0;
    else
      status <= (status & ~clear_mask) | event_pulse;
  end

  // Summary bits follow children only; writes never reach them
  always_comb
  begin
    for (int g = 0; g < NUM_GROUPS; g++)
      summary[g] = |status[g*GROUP_SIZE +: GROUP_SIZE];
  end

  assign pending = |(status & event_enable);
  assign mgmt_req = mgmt_int_global_enable && !acpi_route_select && pending;

  ////////////////////////////////////////////////////////////////////////////
  // End-of-handler handshake
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      end_of_handler_flag <= 1'b0;
      armed <= 1'b0;
    end
    else if (end_of_handler_flag && mgmt_req)
      end_of_handler_flag <= 1'b0;
    else if (eoh_write && status == '0)
    begin
      // A write with any status left is dropped; handler must retry
      end_of_handler_flag <= 1'b1;
      armed <= 1'b1;
    end
  end

  // Registered output gives one inactive cycle after every flag set
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      mgmt_interrupt_n <= 1'b1;
      config_power_interrupt <= 1'b0;
    end
    else
    begin
      mgmt_interrupt_n <= !(armed && !end_of_handler_flag);
      config_power_interrupt <= acpi_route_select && pending;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  logic [31:0] read_val;
  logic read_hit;

  always_comb
  begin
    read_val = MIH_RST_ZERO;
    read_hit = 1'b1;
    case (word_addr(s_axi_araddr))
      MIH_OFF_CTRL:
      begin
        read_val[MIH_CTRL_GLOBAL_EN] = mgmt_int_global_enable;
        read_val[MIH_CTRL_ROUTE] = acpi_route_select;
        read_val[MIH_CTRL_EOH] = end_of_handler_flag;
        read_val[MIH_CTRL_ARMED] = armed;
      end
      MIH_OFF_STAT:
      begin
        read_val[NUM_EVENTS-1:0] = status;
        read_val[MIH_STAT_SUM_LSB +: NUM_GROUPS] = summary;
      end
      MIH_OFF_ENAB:
        read_val[NUM_EVENTS-1:0] = event_enable;
      default:
        read_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= MIH_RST_ZERO;
      s_axi_rresp <= MIH_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_val;
      s_axi_rresp <= read_hit ? MIH_RESP_OKAY : MIH_RESP_DECERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  global_gate_a: assert property ($fell(mgmt_interrupt_n) |-> $past(mgmt_req, 2))
    else $error("interrupt asserted without enabled request");
  flag_clear_a: assert property (end_of_handler_flag && mgmt_req |=> !end_of_handler_flag)
    else $error("flag not cleared on enabled event");
  hold_low_a: assert property (armed && !end_of_handler_flag |=> !mgmt_interrupt_n)
    else $error("interrupt released while flag cleared");
  no_repulse_a: assert property (armed && !end_of_handler_flag && $past(armed && !end_of_handler_flag)
                                 |-> !mgmt_interrupt_n)
    else $error("extra interrupt pulse while flag cleared");
  gap_high_a: assert property ($rose(end_of_handler_flag) |=> mgmt_interrupt_n)
    else $error("no inactive cycle after flag set");
  reassert_a: assert property (end_of_handler_flag && mgmt_req |-> ##2 !mgmt_interrupt_n)
    else $error("pending request did not re-assert");
  set_blocked_a: assert property ($rose(end_of_handler_flag) |-> $past(status) == '0)
    else $error("flag set with status pending");
  route_sel_a: assert property (config_power_interrupt |-> $past(acpi_route_select && pending))
    else $error("config-power interrupt without route select");
  status_keep_a: assert property (##1 (($past(status) & ~$past(clear_mask)) & ~status) == '0)
    else $error("status bit lost without clear");

endmodule : mih_core

// ### hw/mih_pkg.sv
// Purpose: Constants for the management interrupt handshake block
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes: Register offsets and bit positions are shared by design and bench
package mih_pkg;
  // Register byte offsets
  localparam logic [7:0] MIH_OFF_CTRL = 8'h00;
  localparam logic [7:0] MIH_OFF_STAT = 8'h04;
  localparam logic [7:0] MIH_OFF_ENAB = 8'h08;
  // Control register fields
  localparam int MIH_CTRL_GLOBAL_EN = 0;
  localparam int MIH_CTRL_ROUTE = 1;
  localparam int MIH_CTRL_EOH = 2;
  localparam int MIH_CTRL_ARMED = 3;
  // Status register: summary bits start here
  localparam int MIH_STAT_SUM_LSB = 16;
  // Reset values
  localparam logic [31:0] MIH_RST_ZERO = 32'h0000_0000;
  // AXI responses
  localparam logic [1:0] MIH_RESP_OKAY = 2'h0;
  localparam logic [1:0] MIH_RESP_DECERR = 2'h3;
endpackage : mih_pkg

// ### testbench/mih_host_model.sv
// Purpose: Processor side of the management interrupt
// Assumes: Interrupt is a level, active low, on mclk
// Notes: Counts entries into management mode
module mih_host_model
(
  input wire logic mclk, // Clock
  input wire logic nrst, // Async reset, active low
  input wire logic mgmt_interrupt_n, // Interrupt from block
  output int entries // Entries into management mode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_n;
  // Each falling edge is one entry into processor_management_mode
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      prev_n <= 1'b1;
      entries <= 0;
    end
    else
    begin
      prev_n <= mgmt_interrupt_n;
      if (prev_n && !mgmt_interrupt_n)
        entries <= entries + 1;
    end
  end
endmodule : mih_host_model

// ### testbench/mih_core_tb.sv
// Purpose: Self-checking bench for the management interrupt block
// Assumes: AXI4-Lite master driven after each rising edge
// Notes: The handler sequence is played by the bench tasks
module mih_core_tb;
  import mih_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, nrst = 0;
  logic [7:0] event_pulse = '0, awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, int_n, cfg_int;
  logic [1:0] bresp, rresp, rr, wresp;
  int n_errors = 0, check_count = 0, entries;
  always #4 mclk = ~mclk;
  mih_core dut (.mclk(mclk), .nrst(nrst), .event_pulse(event_pulse), .mgmt_interrupt_n(int_n),
    .config_power_interrupt(cfg_int), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  mih_host_model host (.mclk(mclk), .nrst(nrst), .mgmt_interrupt_n(int_n), .entries(entries));
  //////////////////////////////////////////////////////////////////////////////
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask : tick
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Values probed at tick are the ones the next edge samples
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_t, w_t, b_t, aw_p, w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    b_t = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (int t = 0; t < 40; t++)
    begin
      aw_t = aw_p && awready;
      w_t = w_p && wready;
      b_t = bvalid;
      wresp = bresp;
      tick;
      if (aw_t)
      begin
        awvalid <= 0;
        aw_p = 1'b0;
      end
      if (w_t)
      begin
        wvalid <= 0;
        w_p = 1'b0;
      end
      if (b_t) break;
    end
    chk("bvalid seen", 1, b_t);
    bready <= 0;
    tick;
  endtask : wr
  task automatic rdw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_t, r_t, ar_p;
    ar_p = 1'b1;
    r_t = 1'b0;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (int t = 0; t < 40; t++)
    begin
      ar_t = ar_p && arready;
      r_t = rvalid;
      d = rdata;
      r = rresp;
      tick;
      if (ar_t)
      begin
        arvalid <= 0;
        ar_p = 1'b0;
      end
      if (r_t) break;
    end
    chk("rvalid seen", 1, r_t);
    rready <= 0;
    tick;
  endtask : rdw
  task automatic chk_reg(input string what, input logic [7:0] a, input logic [31:0] exp);
    rdw(a, rd, rr);
    chk(what, exp, rd);
  endtask : chk_reg
  // Event pulse, then enough cycles for the interrupt to settle
  task automatic ev(input int i);
    event_pulse <= 8'h01 << i;
    tick;
    event_pulse <= 8'h00;
    repeat (4) tick;
  endtask : ev
  //////////////////////////////////////////////////////////////////////////////
  task automatic test_disabled;
    chk_reg("ctrl reset", MIH_OFF_CTRL, MIH_RST_ZERO);
    chk_reg("stat reset", MIH_OFF_STAT, MIH_RST_ZERO);
    rdw(8'h0c, rd, rr);
    chk("unmapped resp", {30'h0, MIH_RESP_DECERR}, {30'h0, rr});
    wr(8'h0c, 32'h0000_0007);
    chk("unmapped wresp", {30'h0, MIH_RESP_DECERR}, {30'h0, wresp});
    wr(MIH_OFF_ENAB, 32'h0000_0001);
    chk("mapped wresp", {30'h0, MIH_RESP_OKAY}, {30'h0, wresp});
    wr(MIH_OFF_CTRL, 32'h0000_0004);
    ev(0);
    chk("int_n no enable", 1, int_n);
    chk_reg("ctrl flag kept", MIH_OFF_CTRL, 32'h0000_000c);
    wr(MIH_OFF_STAT, 32'h0000_0001);
    $display("test_disabled done");
  endtask : test_disabled
  task automatic test_handshake;
    wr(MIH_OFF_CTRL, 32'h0000_0005);
    chk("int_n armed idle", 1, int_n);
    ev(0);
    chk("int_n asserted", 0, int_n);
    chk_reg("flag cleared", MIH_OFF_CTRL, 32'h0000_0009);
    ev(4);
    ev(0);
    chk("single entry", 1, entries);
    chk_reg("status held", MIH_OFF_STAT, 32'h0003_0011);
    wr(MIH_OFF_STAT, 32'h0003_0000);
    chk_reg("summary kept", MIH_OFF_STAT, 32'h0003_0011);
    wr(MIH_OFF_CTRL, 32'h0000_0005);
    chk_reg("flag refused", MIH_OFF_CTRL, 32'h0000_0009);
    chk("int_n still low", 0, int_n);
    wr(MIH_OFF_STAT, 32'h0000_0011);
    chk_reg("summary clear", MIH_OFF_STAT, MIH_RST_ZERO);
    wr(MIH_OFF_CTRL, 32'h0000_0005);
    chk("int_n released", 1, int_n);
    chk_reg("flag set", MIH_OFF_CTRL, 32'h0000_000d);
    ev(0);
    chk("int_n again", 0, int_n);
    chk("second entry", 2, entries);
    wr(MIH_OFF_STAT, 32'h0000_0001);
    wr(MIH_OFF_CTRL, 32'h0000_0005);
    $display("test_handshake done");
  endtask : test_handshake
  // Event lands on the flag-set edge, so the flag drops again after one high cycle
  task automatic test_reassert;
    ev(0);
    chk("int_n in handler", 0, int_n);
    wr(MIH_OFF_STAT, 32'h0000_0001);
    fork
      wr(MIH_OFF_CTRL, 32'h0000_0005);
      begin
        tick;
        event_pulse <= 8'h01;
        tick;
        event_pulse <= 8'h00;
      end
    join
    tick;
    chk("reentry", 4, entries);
    chk("int_n reasserted", 0, int_n);
    chk_reg("flag cleared again", MIH_OFF_CTRL, 32'h0000_0009);
    wr(MIH_OFF_STAT, 32'h0000_0001);
    wr(MIH_OFF_CTRL, 32'h0000_0005);
    $display("test_reassert done");
  endtask : test_reassert
  task automatic test_route;
    wr(MIH_OFF_CTRL, 32'h0000_0003);
    ev(0);
    chk("cfg int", 1, cfg_int);
    chk("int_n routed away", 1, int_n);
    wr(MIH_OFF_STAT, 32'h0000_0001);
    tick;
    chk("cfg int clear", 0, cfg_int);
    $display("test_route done");
  endtask : test_route
  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (5) tick;
    nrst <= 1;
    tick;
    test_disabled;
    test_handshake;
    test_reassert;
    test_route;
    report_and_stop;
  end
  // Whole run is under two hundred cycles
  initial
  begin
    #100000;
    n_errors++;
    report_and_stop;
  end
endmodule : mih_core_tb
